// ---- rtl/tsw_addr_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tsw_consts.svh"

// Splits the 12-bit processor address into block selects and index
module tsw_addr_decode
    import tsw_pkg::*;
(
    input  wire logic [11:0] addr,
    output tsw_dec_t         dec
);
    // ----------------------------------------------------------------
    // Block select from the top two bits
    // ----------------------------------------------------------------
    always_comb
    begin
        dec.dm_sel  = (addr[11:10] == `TSW_SEL_DM);
        dec.cm_sel  = (addr[11:10] == `TSW_SEL_CM);
        dec.reg_sel = (addr[11:10] == `TSW_SEL_REG);
        dec.reg_idx = addr[9:6];
        dec.loc     = addr[9:0];
    end
endmodule : tsw_addr_decode

`default_nettype wire

// ---- rtl/tsw_consts.svh ----
`ifndef TSW_CONSTS_SVH
`define TSW_CONSTS_SVH

// ----------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------
`define TSW_SEL_DM       2'h3
`define TSW_SEL_CM       2'h2
`define TSW_SEL_REG      2'h1
`define TSW_REG_CTRL     4'h0
`define TSW_REG_ALIGN    4'h1
`define TSW_REG_SKEW0    4'h2
`define TSW_REG_SKEW7    4'h9
`define TSW_SKEW_REGS    8

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define TSW_CTRL_RESET   16'h0000
`define TSW_CTRL_MASK    16'h03fc
`define TSW_WORD_ZERO    16'h0000
`define TSW_BYTE_ZERO    8'h00
`define TSW_FILL_LOW     12'h000

// ----------------------------------------------------------------
// Frame timing
// ----------------------------------------------------------------
`define TSW_LAST_SLOT    5'h1f
`define TSW_LAST_LOC     10'h3ff
`define TSW_VAR_GAP      6'h02
`define TSW_BANK_LAST    2'h2
`define TSW_BANK_FIRST   2'h0

`endif

// ---- rtl/tsw_pkg.sv ----
package tsw_pkg;

    // Connection memory word
    typedef struct packed {
        logic       loop_back;
        logic       delay_select;
        logic       out_on;
        logic       cpu_src;
        logic [1:0] spare;
        logic [4:0] src_stream;
        logic [4:0] src_slot;
    } tsw_cm_t;

    // Control register layout
    typedef struct packed {
        logic [5:0] unused_hi;
        logic       fill_arm;
        logic [3:0] fill_pattern;
        logic       fill_go;
        logic       standby_out;
        logic       frame_eval;
        logic [1:0] unused_lo;
    } tsw_ctrl_t;

    // Processor port request
    typedef struct packed {
        logic        cs;
        logic        we;
        logic [11:0] addr;
        logic [15:0] wdata;
    } tsw_cpu_req_t;

    // Decoded address
    typedef struct packed {
        logic       dm_sel;
        logic       cm_sel;
        logic       reg_sel;
        logic [3:0] reg_idx;
        logic [9:0] loc;
    } tsw_dec_t;

    typedef logic [31:0][7:0] tsw_stream_bus_t;

    typedef enum logic {TSW_FILL_IDLE, TSW_FILL_RUN} tsw_fill_t;

endpackage : tsw_pkg

// ---- rtl/tsw_switch_core.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tsw_consts.svh"

// Summary of operation
// - Per-channel bit picks variable or constant delay
// - Variable: near channels next frame, far same
// - Variable delay follows slot distance, minimum three
// - Constant: written frame n, read frame n+2
// - RAM-style port, single-cycle access
// - Top two address bits select block
// - Ten low bits: stream and channel index
// - Data memory read-only; others read/write
// - Bits 9..6 select register, rest ignored
// - Master pin or standby bit enables drivers
// - Per-channel enable bit gates each slot
// - Processor mode outputs connection memory byte
// - Loopback feeds TX slot into RX slot
// - Fill starts on go only when armed
// - Fill writes pattern high, clears low bits
// - Device clears go when fill ends
module tsw_switch_core
    import tsw_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rstn,
    input  wire logic            master_output_pin,
    input  wire logic            frame_pulse_n,
    input  wire logic            slot_strobe,
    input  wire tsw_stream_bus_t rx_data,
    input  wire tsw_cpu_req_t    cpu_req,
    output logic [15:0]          cpu_rdata,
    output tsw_stream_bus_t      tx_data,
    output logic [31:0]          tx_oe_n,
    output logic [4:0]           tx_slot
);
    // ----------------------------------------------------------------
    // Storage and state
    // ----------------------------------------------------------------
    tsw_cm_t         cm [0:1023];
    logic [7:0]      dm [0:2][0:1023];
    tsw_ctrl_t       ctrl;
    logic [15:0]     align_reg;
    logic [15:0]     skew [0:`TSW_SKEW_REGS-1];
    logic [4:0]      slot_cnt;
    logic [1:0]      cur_bank;
    logic            frame_prev;
    tsw_fill_t       fill_state;
    logic [9:0]      fill_loc;

    tsw_ctrl_t       next_ctrl;
    logic [15:0]     next_align_reg;
    logic [15:0]     next_skew [0:`TSW_SKEW_REGS-1];
    logic [4:0]      next_slot_cnt;
    logic [1:0]      next_cur_bank;
    logic            next_frame_prev;
    tsw_fill_t       next_fill_state;
    logic [9:0]      next_fill_loc;
    logic [15:0]     next_cpu_rdata;
    tsw_stream_bus_t next_tx_data;
    logic [31:0]     next_tx_oe_n;
    logic [4:0]      next_tx_slot;

    logic            ode_level;
    logic            frame_level;
    logic            frame_fall;
    logic            master_en;
    logic [1:0]      prev_bank;
    logic [1:0]      prev2_bank;
    tsw_dec_t        dec;
    logic            cm_we;
    logic [9:0]      cm_idx;
    tsw_cm_t         cm_wdata;
    logic [2:0]      skew_sel;

    tsw_cm_t         cur_cm   [0:31];
    logic [1:0]      rd_bank  [0:31];
    logic [7:0]      tx_byte  [0:31];
    logic [7:0]      wr_byte  [0:31];
    logic [31:0]     drive;

    // Bank after / before in the three-frame ring
    function automatic logic [1:0] bank_after(input logic [1:0] b);
        bank_after = (b == `TSW_BANK_LAST) ? `TSW_BANK_FIRST : b + 2'h1;
    endfunction : bank_after

    function automatic logic [1:0] bank_before(input logic [1:0] b);
        bank_before = (b == `TSW_BANK_FIRST) ? `TSW_BANK_LAST : b - 2'h1;
    endfunction : bank_before

    // ----------------------------------------------------------------
    // Pin synchronisers and address decode
    // ----------------------------------------------------------------
    tsw_sync3 #(.RESET_VAL(1'b0)) u_ode_sync
    (
        .clk  (clk),
        .rstn (rstn),
        .d    (master_output_pin),
        .q    (ode_level)
    );

    tsw_sync3 #(.RESET_VAL(1'b1)) u_frame_sync
    (
        .clk  (clk),
        .rstn (rstn),
        .d    (frame_pulse_n),
        .q    (frame_level)
    );

    tsw_addr_decode u_decode
    (
        .addr (cpu_req.addr),
        .dec  (dec)
    );

    // Master enable and bank ring
    assign frame_fall = frame_prev & ~frame_level;
    assign master_en  = ode_level | ctrl.standby_out;
    assign prev_bank  = bank_before(cur_bank);
    assign prev2_bank = bank_before(prev_bank);
    assign skew_sel   = 3'(dec.reg_idx - `TSW_REG_SKEW0);

    // ----------------------------------------------------------------
    // Frame and slot timing
    // ----------------------------------------------------------------
    always_comb
    begin
        next_frame_prev = frame_level;
        next_slot_cnt   = slot_cnt;
        next_cur_bank   = cur_bank;
        if (frame_fall)
        begin
            next_slot_cnt = 5'h00;
            if (slot_cnt != 5'h00)
                next_cur_bank = bank_after(cur_bank);
        end
        else if (slot_strobe)
        begin
            next_slot_cnt = slot_cnt + 5'h01;
            if (slot_cnt == `TSW_LAST_SLOT)
                next_cur_bank = bank_after(cur_bank);
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            frame_prev <= 1'b1;
            slot_cnt   <= 5'h00;
            cur_bank   <= 2'h0;
        end
        else
        begin
            frame_prev <= next_frame_prev;
            slot_cnt   <= next_slot_cnt;
            cur_bank   <= next_cur_bank;
        end
    end

    // ----------------------------------------------------------------
    // Per-stream switching path
    // ----------------------------------------------------------------
    genvar s;
    generate
        for (s = 0; s < 32; s++)
        begin : g_stream
            logic late;
            assign cur_cm[s] = cm[{5'(s), slot_cnt}];
            // Source channel at least three slots back is still this frame
            assign late = {1'b0, slot_cnt} > ({1'b0, cur_cm[s].src_slot} + `TSW_VAR_GAP);
            assign rd_bank[s] = cur_cm[s].delay_select ? prev2_bank
                              : (late ? cur_bank : prev_bank);
            assign tx_byte[s] = cur_cm[s].cpu_src ? cur_cm[s][7:0]
                              : dm[rd_bank[s]][{cur_cm[s].src_stream, cur_cm[s].src_slot}];
            assign wr_byte[s] = cur_cm[s].loop_back ? tx_byte[s] : rx_data[s];
            assign drive[s]   = master_en & cur_cm[s].out_on;
        end
    endgenerate

    // Output stage, updated once per slot
    always_comb
    begin
        next_tx_data = tx_data;
        next_tx_oe_n = tx_oe_n;
        next_tx_slot = tx_slot;
        if (slot_strobe)
        begin
            for (int i = 0; i < 32; i++)
            begin
                next_tx_data[i] = tx_byte[i];
                next_tx_oe_n[i] = ~drive[i];
            end
            next_tx_slot = slot_cnt;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_data <= '0;
            tx_oe_n <= '1;
            tx_slot <= 5'h00;
        end
        else
        begin
            tx_data <= next_tx_data;
            tx_oe_n <= next_tx_oe_n;
            tx_slot <= next_tx_slot;
        end
    end

    // Data memory capture into the current frame bank
    always_ff @(posedge clk)
    begin
        if (slot_strobe)
        begin
            for (int i = 0; i < 32; i++)
                dm[cur_bank][{5'(i), slot_cnt}] <= wr_byte[i];
        end
    end

    // ----------------------------------------------------------------
    // Processor port and bulk fill
    // ----------------------------------------------------------------
    always_comb
    begin
        next_ctrl       = ctrl;
        next_align_reg  = align_reg;
        next_skew       = skew;
        next_fill_state = fill_state;
        next_fill_loc   = fill_loc;
        next_cpu_rdata  = cpu_rdata;
        cm_we           = 1'b0;
        cm_idx          = dec.loc;
        cm_wdata        = cpu_req.wdata;
        unique case (fill_state)
            TSW_FILL_IDLE:
            begin
                if (ctrl.fill_go && ctrl.fill_arm)
                begin
                    next_fill_state = TSW_FILL_RUN;
                    next_fill_loc   = 10'h000;
                end
            end
            TSW_FILL_RUN:
            begin
                cm_we         = 1'b1;
                cm_idx        = fill_loc;
                cm_wdata      = {ctrl.fill_pattern, `TSW_FILL_LOW};
                next_fill_loc = fill_loc + 10'h001;
                if (fill_loc == `TSW_LAST_LOC)
                begin
                    next_fill_state   = TSW_FILL_IDLE;
                    next_ctrl.fill_go = 1'b0;
                end
            end
        endcase
        if (cpu_req.cs && cpu_req.we)
        begin
            // Data memory writes fall through untouched
            if (dec.cm_sel && fill_state == TSW_FILL_IDLE)
                cm_we = 1'b1;
            else if (dec.reg_sel)
            begin
                if (dec.reg_idx == `TSW_REG_CTRL)
                begin
                    next_ctrl = tsw_ctrl_t'(cpu_req.wdata & `TSW_CTRL_MASK);
                    // Go is refused unless arm was already set
                    next_ctrl.fill_go = next_ctrl.fill_go & ctrl.fill_arm;
                end
                else if (dec.reg_idx == `TSW_REG_ALIGN)
                    next_align_reg = cpu_req.wdata;
                else if (dec.reg_idx <= `TSW_REG_SKEW7)
                    next_skew[skew_sel] = cpu_req.wdata;
            end
        end
        else if (cpu_req.cs)
        begin
            next_cpu_rdata = `TSW_WORD_ZERO;
            if (dec.dm_sel)
                next_cpu_rdata = {`TSW_BYTE_ZERO, dm[prev_bank][dec.loc]};
            else if (dec.cm_sel)
                next_cpu_rdata = cm[dec.loc];
            else if (dec.reg_sel)
            begin
                if (dec.reg_idx == `TSW_REG_CTRL)
                    next_cpu_rdata = ctrl;
                else if (dec.reg_idx == `TSW_REG_ALIGN)
                    next_cpu_rdata = align_reg;
                else if (dec.reg_idx <= `TSW_REG_SKEW7)
                    next_cpu_rdata = skew[skew_sel];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl       <= tsw_ctrl_t'(`TSW_CTRL_RESET);
            align_reg  <= `TSW_WORD_ZERO;
            fill_state <= TSW_FILL_IDLE;
            fill_loc   <= 10'h000;
            cpu_rdata  <= `TSW_WORD_ZERO;
            for (int i = 0; i < `TSW_SKEW_REGS; i++)
                skew[i] <= `TSW_WORD_ZERO;
        end
        else
        begin
            ctrl       <= next_ctrl;
            align_reg  <= next_align_reg;
            fill_state <= next_fill_state;
            fill_loc   <= next_fill_loc;
            cpu_rdata  <= next_cpu_rdata;
            skew       <= next_skew;
        end
    end

    // Connection memory, undefined until programmed
    always_ff @(posedge clk)
    begin
        if (cm_we)
            cm[cm_idx] <= cm_wdata;
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_oe_master: assert property (@(posedge clk) disable iff (!rstn)
        slot_strobe |=> tx_oe_n[0] == !($past(master_en) && $past(cur_cm[0].out_on)))
        else $error("stream 0 enable does not follow master and channel bits");

    chk_proc_mode: assert property (@(posedge clk) disable iff (!rstn)
        slot_strobe && cur_cm[0].cpu_src
            |=> tx_data[0] == $past(cur_cm[0][7:0]))
        else $error("processor mode byte not taken from connection memory");

    chk_var_bank: assert property (@(posedge clk) disable iff (!rstn)
        !cur_cm[0].delay_select && ({1'b0, slot_cnt} > {1'b0, cur_cm[0].src_slot} + `TSW_VAR_GAP)
            |-> rd_bank[0] == cur_bank)
        else $error("far variable channel not read from current frame");

    chk_const_bank: assert property (@(posedge clk) disable iff (!rstn)
        cur_cm[0].delay_select |-> rd_bank[0] != cur_bank && rd_bank[0] != prev_bank)
        else $error("constant delay not read two frames back");

    chk_fill_arm: assert property (@(posedge clk) disable iff (!rstn)
        fill_state == TSW_FILL_IDLE ##1 fill_state == TSW_FILL_RUN |-> $past(ctrl.fill_arm))
        else $error("fill started without arm");

    chk_fill_word: assert property (@(posedge clk) disable iff (!rstn)
        fill_state == TSW_FILL_RUN
            |=> cm[$past(fill_loc)] == {$past(ctrl.fill_pattern), `TSW_FILL_LOW})
        else $error("fill word wrong");

    chk_fill_done: assert property (@(posedge clk) disable iff (!rstn)
        fill_state == TSW_FILL_RUN && fill_loc == `TSW_LAST_LOC && !(cpu_req.cs && cpu_req.we)
            |=> !ctrl.fill_go && fill_state == TSW_FILL_IDLE)
        else $error("go not cleared at fill end");

    chk_unmapped_zero: assert property (@(posedge clk) disable iff (!rstn)
        cpu_req.cs && !cpu_req.we && dec.reg_sel && dec.reg_idx > `TSW_REG_SKEW7
            |=> cpu_rdata == `TSW_WORD_ZERO)
        else $error("unassigned register did not read zero");

    chk_cm_write: assert property (@(posedge clk) disable iff (!rstn)
        cpu_req.cs && cpu_req.we && dec.cm_sel && fill_state == TSW_FILL_IDLE
            |=> cm[$past(dec.loc)] == $past(cpu_req.wdata))
        else $error("connection memory write lost");

endmodule : tsw_switch_core

`default_nettype wire

// ---- rtl/tsw_sync3.sv ----
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; output follows once stages two and three agree
module tsw_sync3
#(
    parameter bit RESET_VAL = 1'b0
)
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic d,
    output logic      q
);
    logic s1;
    logic s2;
    logic s3;
    logic next_q;

    // ----------------------------------------------------------------
    // Agreement filter
    // ----------------------------------------------------------------
    always_comb
    begin
        next_q = (s2 == s3) ? s3 : q;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1 <= RESET_VAL;
            s2 <= RESET_VAL;
            s3 <= RESET_VAL;
            q  <= RESET_VAL;
        end
        else
        begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q  <= next_q;
        end
    end
endmodule : tsw_sync3

`default_nettype wire

// ---- sim/test_tdm_slot_switch_control.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_tdm_slot_switch_control
    import tsw_pkg::*;
;
    typedef struct {logic we; logic [11:0] a; logic [15:0] d;} tsw_row_t;

    logic            clk, rstn, pin, fp_n, strobe, st1, st2;
    tsw_stream_bus_t rx, tx;
    tsw_cpu_req_t    req;
    logic [15:0]     rdata, rd;
    logic [31:0]     oe_n;
    logic [4:0]      slot;
    logic [7:0]      fidx, f;
    tsw_stream_bus_t cap_d [32];
    logic [31:0]     cap_oe [32];
    tsw_row_t        rows [$];
    int              fails, total_checks, n;
    logic [4:0]      os [5] = '{5'h05, 5'h06, 5'h07, 5'h08, 5'h09};
    logic [4:0]      ot [5] = '{5'h0d, 5'h0c, 5'h05, 5'h14, 5'h05};
    logic [7:0]      dd [5] = '{8'h00, 8'h01, 8'h01, 8'h02, 8'h02};
    logic [15:0]     dw [5] = '{16'h206a, 16'h206a, 16'h206a, 16'h606a, 16'h606a};

    // ----------------------------------------------------------------
    // Clock, partner and design
    // ----------------------------------------------------------------
    always #2.5 clk = ~clk;

    tsw_tdm_source u_src (.clk(clk), .rstn(rstn), .frame_pulse_n(fp_n), .slot_strobe(strobe),
                          .rx_data(rx), .frame_idx(fidx));

    tsw_switch_core dut (.clk(clk), .rstn(rstn), .master_output_pin(pin), .frame_pulse_n(fp_n),
                         .slot_strobe(strobe), .rx_data(rx), .cpu_req(req), .cpu_rdata(rdata),
                         .tx_data(tx), .tx_oe_n(oe_n), .tx_slot(slot));

    // Capture each slot's outputs once they have settled after the strobe
    always @(posedge clk)
    begin
        st1 <= strobe;
        st2 <= st1;
    end
    always @(negedge clk)
    begin
        if (st2)
        begin
            cap_d[slot]  <= tx;
            cap_oe[slot] <= oe_n;
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check_val

    // One access: held through the taking edge, data read a cycle later
    task automatic cpu_op(input logic we, input logic [11:0] a, input logic [15:0] d);
        @(negedge clk);
        req = '{cs: 1'b1, we: we, addr: a, wdata: d};
        @(negedge clk);
        req.cs = 1'b0;
        @(negedge clk);
        rd = rdata;
    endtask : cpu_op

    task automatic wait_frames(input int k);
        repeat (k) @(fidx);
        repeat (4) @(negedge clk);
        f = fidx - 8'h01;
    endtask : wait_frames

    task automatic wrap_up;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // Watchdog against a hang
    initial
    begin
        #100000;
        fails++;
        wrap_up();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0; rstn = 1'b0; pin = 1'b0; req = '0;
        st1 = 1'b0; st2 = 1'b0; fails = 0; total_checks = 0;
        repeat (2) @(negedge clk);
        check_val(oe_n, 32'hffffffff);
        check_val(rdata, 32'h0);
        @(negedge clk);
        rstn = 1'b1;
        // Register rows: writes, then reads with the value expected
        rows.push_back('{1'b1, 12'h400, 16'hffff});
        rows.push_back('{1'b0, 12'h400, 16'h03ec});
        rows.push_back('{1'b1, 12'h47f, 16'h1234});
        rows.push_back('{1'b0, 12'h440, 16'h1234});
        for (int k = 0; k < 8; k++)
        begin
            rows.push_back('{1'b1, 12'h400 | 12'((k + 2) << 6), 16'h0100 + 16'(k)});
            rows.push_back('{1'b0, 12'h400 | 12'((k + 2) << 6), 16'h0100 + 16'(k)});
        end
        rows.push_back('{1'b1, 12'h680, 16'hbeef});
        rows.push_back('{1'b0, 12'h680, 16'h0000});
        rows.push_back('{1'b1, 12'h040, 16'h5555});
        rows.push_back('{1'b0, 12'h123, 16'h0000});
        rows.push_back('{1'b1, 12'h8ab, 16'h233d});
        rows.push_back('{1'b0, 12'h8ab, 16'h233d});
        rows.push_back('{1'b1, 12'h400, 16'h0000});
        rows.push_back('{1'b0, 12'h400, 16'h0000});
        for (int k = 0; k < 8; k++)
        begin
            rows.push_back('{1'b1, 12'h400 | 12'((k + 2) << 6), 16'h0000});
            rows.push_back('{1'b0, 12'h400 | 12'((k + 2) << 6), 16'h0000});
        end
        foreach (rows[i])
        begin
            cpu_op(rows[i].we, rows[i].a, rows[i].d);
            if (!rows[i].we)
                check_val(rd, rows[i].d);
        end
        // Bulk fill; a connection write during the fill must be lost
        cpu_op(1'b1, 12'h400, 16'h0260);
        cpu_op(1'b1, 12'h400, 16'h0270);
        cpu_op(1'b1, 12'h800, 16'h1234);
        n = 0;
        rd = 16'h0010;
        while (rd[4] && n < 800)
        begin
            cpu_op(1'b0, 12'h400, 16'h0000);
            n++;
        end
        check_val(rd, 16'h0260);
        check_val(32'(n > 300), 32'h1);
        cpu_op(1'b0, 12'h800, 16'h0000);
        check_val(rd, 16'h3000);
        cpu_op(1'b0, 12'hbff, 16'h0000);
        check_val(rd, 16'h3000);
        // Paths set up while the master pin holds outputs off
        for (int i = 0; i < 5; i++)
            cpu_op(1'b1, {2'h2, os[i], ot[i]}, dw[i]);
        cpu_op(1'b1, {2'h2, 5'h0a, 5'h00}, 16'h303c);
        cpu_op(1'b1, {2'h2, 5'h0b, 5'h01}, 16'h0000);
        cpu_op(1'b1, {2'h2, 5'h0c, 5'h04}, 16'hb077);
        cpu_op(1'b1, {2'h2, 5'h0d, 5'h14}, 16'h2184);
        pin = 1'b1;
        wait_frames(3);
        for (int i = 0; i < 5; i++)
            check_val(cap_d[ot[i]][os[i]], u_src.rx_byte(f - dd[i], 5'h03, 5'h0a));
        check_val(cap_d[0][10], 8'h3c);
        check_val(cap_oe[0][10], 1'b0);
        check_val(cap_oe[1][11], 1'b1);
        check_val(cap_d[20][13], 8'h77);
        cpu_op(1'b0, 12'hd84, 16'h0000);
        check_val(rd, 16'h0077);
        cpu_op(1'b0, 12'hc6a, 16'h0000);
        check_val(rd, {8'h00, u_src.rx_byte(f, 5'h03, 5'h0a)});
        cpu_op(1'b1, 12'hc6a, 16'hffff);
        cpu_op(1'b0, 12'hc6a, 16'h0000);
        check_val(rd, {8'h00, u_src.rx_byte(f, 5'h03, 5'h0a)});
        // Master pin against standby bit
        for (int p = 0; p < 2; p++)
        begin
            for (int s = 0; s < 2; s++)
            begin
                pin = p[0];
                cpu_op(1'b1, 12'h400, {12'h026, s[0], 3'h0});
                wait_frames(2);
                check_val(cap_oe[7], (p | s) ? 32'h0 : 32'hffffffff);
                check_val(cap_oe[1][11], 1'b1);
            end
        end
        wrap_up();
    end
endmodule : test_tdm_slot_switch_control

`default_nettype wire

// ---- sim/tsw_tdm_source.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Backplane stream source
// ----------------------------------------------------------------
module tsw_tdm_source
    import tsw_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    output logic            frame_pulse_n,
    output logic            slot_strobe,
    output tsw_stream_bus_t rx_data,
    output logic [7:0]      frame_idx
);
    logic [7:0] cnt;
    logic [4:0] slot;

    // Byte carried by stream s, slot t of frame f
    function automatic logic [7:0] rx_byte(input logic [7:0] f, input logic [4:0] s,
                                           input logic [4:0] t);
        return f * 8'h1d + {3'h0, s} * 8'h07 + {3'h0, t};
    endfunction : rx_byte

    // 136-cycle frame: pulse low 4 cycles, 32 strobes 4 cycles apart
    always @(negedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt       <= 8'h04;
            frame_idx <= 8'h00;
        end
        else if (cnt == 8'h87)
        begin
            cnt       <= 8'h00;
            frame_idx <= frame_idx + 8'h01;
        end
        else
            cnt <= cnt + 8'h01;
    end

    // Slot timing; data is inverted away from the strobe so stale bytes never pass
    assign slot          = 5'((cnt - 8'h08) >> 2);
    assign frame_pulse_n = (cnt >= 8'h04);
    assign slot_strobe   = (cnt >= 8'h08) && (cnt[1:0] == 2'h3);
    always_comb
    begin
        for (int i = 0; i < 32; i++)
            rx_data[i] = slot_strobe ? rx_byte(frame_idx, 5'(i), slot)
                                     : ~rx_byte(frame_idx, 5'(i), slot);
    end
endmodule : tsw_tdm_source

`default_nettype wire
